// File: rtl/btone_defines.svh
// register offsets, reset values and timing counts for the tone output block
`ifndef BTONE_DEFINES_SVH
`define BTONE_DEFINES_SVH

// register indices, and their byte addresses at four times the index
`define BTONE_IDX_FUNC 8'h13
`define BTONE_IDX_FREQ 8'h14
`define BTONE_IDX_DIR 8'h6C
`define BTONE_IDX_LATCH 8'h70
`define BTONE_IDX_PINS 8'h71
`define BTONE_ADDR_FUNC 12'h04C
`define BTONE_ADDR_FREQ 12'h050
`define BTONE_ADDR_DIR 12'h1B0
`define BTONE_ADDR_LATCH 12'h1C0
`define BTONE_ADDR_PINS 12'h1C4

// reset values
`define BTONE_RST_FUNC 4'h0
`define BTONE_RST_FREQ 4'h0
`define BTONE_RST_DIR 4'h0
`define BTONE_RST_LATCH 4'h0

// field positions
`define BTONE_FREQ0_LSB 0
`define BTONE_FREQ1_LSB 2

// clock rate and tone frequencies in hertz
`define BTONE_CLK_HZ 100000000
`define BTONE_F_1K 1000
`define BTONE_F_3K 3000
`define BTONE_F_4K 4000
`define BTONE_F_6K7 6700
`define BTONE_F_200 200
`define BTONE_F_67 67

// half-period counts: clock cycles per half wave, rounded down
`define BTONE_HALF(f) (`BTONE_CLK_HZ / (2 * (f)))

// axi-lite response codes
`define BTONE_RESP_OKAY 2'h0
`define BTONE_RESP_SLVERR 2'h2

`endif

// File: rtl/btone_pkg.sv
// types shared by the tone output block
package btone_pkg;

  // control image that steers the pin logic
  typedef struct packed {
    logic [3:0] freq;
    logic [3:0] func;
    logic [3:0] dir;
    logic [3:0] latch;
  } btone_cfg_t;

  // pin drive group for port 1d
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } btone_pins_t;

endpackage : btone_pkg

// File: rtl/btone_top.sv
// tone output block: two square-wave channels on port 1d with axi4-lite registers
// Summary of operation
// - channel 0 on pin a, 1 on b
// - channel 0 codes: 1k, 3k, 4k, 6.7k
// - channel 1 codes: 4k, 3k, 200, 67
// - frequency register 14h, ch0 low, ch1 high
// - every tone is 50 percent duty
// - function register 13h, bits 3:2 zero
// - direction register 6ch, one bit a pin
// - hard resets clear all four registers
// - ce or stop clears freq, func; keep dir
// - halt is ignored; tones and configuration keep running
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "btone_defines.svh"

module btone_top
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_wdt_rst,
  input wire logic i_ce_rst,
  input wire logic i_clk_stop,
  input wire logic i_halt,
  input wire logic [3:0] i_pin_in,
  input wire logic [11:0] i_s_awaddr,
  input wire logic [2:0] i_s_awprot,
  input wire logic i_s_awvalid,
  output logic o_s_awready,
  input wire logic [31:0] i_s_wdata,
  input wire logic [3:0] i_s_wstrb,
  input wire logic i_s_wvalid,
  output logic o_s_wready,
  output logic [1:0] o_s_bresp,
  output logic o_s_bvalid,
  input wire logic i_s_bready,
  input wire logic [11:0] i_s_araddr,
  input wire logic [2:0] i_s_arprot,
  input wire logic i_s_arvalid,
  output logic o_s_arready,
  output logic [31:0] o_s_rdata,
  output logic [1:0] o_s_rresp,
  output logic o_s_rvalid,
  input wire logic i_s_rready,
  output logic [3:0] o_pin_out,
  output logic [3:0] o_pin_oe
);

  // half-period count for a channel and code
  // the result is the number of clock cycles per half wave, so high and low last alike
  function automatic logic [19:0] btone_half(input logic chan, input logic [1:0] code);
    logic [31:0] h;
    h = 32'h0;
    if (chan == 1'b0)
    begin
      case (code)
        2'h0: h = `BTONE_HALF(`BTONE_F_1K);
        2'h1: h = `BTONE_HALF(`BTONE_F_3K);
        2'h2: h = `BTONE_HALF(`BTONE_F_4K);
        default: h = `BTONE_HALF(`BTONE_F_6K7);
      endcase
    end
    else
    begin
      case (code)
        2'h0: h = `BTONE_HALF(`BTONE_F_4K);
        2'h1: h = `BTONE_HALF(`BTONE_F_3K);
        2'h2: h = `BTONE_HALF(`BTONE_F_200);
        default: h = `BTONE_HALF(`BTONE_F_67);
      endcase
    end
    btone_half = h[19:0];
  endfunction : btone_half

  btone_pkg::btone_cfg_t cfg_r; // software configuration
  btone_pkg::btone_pins_t pins_nxt; // next pin drive
  logic [19:0] cnt0_r; // channel 0 half-period counter
  logic [19:0] cnt1_r; // channel 1 half-period counter
  logic tone0_r; // channel 0 square wave
  logic tone1_r; // channel 1 square wave
  logic [11:0] awaddr_r; // captured write address
  logic aw_have_r; // write address held
  logic [31:0] wdata_r; // captured write data
  logic [3:0] wstrb_r; // captured strobes
  logic w_have_r; // write data held
  logic [3:0] pin_in_r; // pin levels seen by reads

  // decode wires
  wire logic soft_clr = i_ce_rst | i_clk_stop; // soft reset group
  wire logic hard_clr = ~i_rst_n | i_wdt_rst; // hard reset group
  wire logic do_write = aw_have_r & w_have_r & ~o_s_bvalid;
  wire logic wr_func = do_write & (awaddr_r == `BTONE_ADDR_FUNC);
  wire logic wr_freq = do_write & (awaddr_r == `BTONE_ADDR_FREQ);
  wire logic wr_dir = do_write & (awaddr_r == `BTONE_ADDR_DIR);
  wire logic wr_latch = do_write & (awaddr_r == `BTONE_ADDR_LATCH);
  wire logic wr_hit = wr_func | wr_freq | wr_dir | wr_latch |
    (do_write & (awaddr_r == `BTONE_ADDR_PINS));
  wire logic wlane = wstrb_r[0]; // registers live in byte lane 0
  wire logic [3:0] wval = wdata_r[3:0];
  wire logic do_read = i_s_arvalid & o_s_arready;
  wire logic [19:0] lim0 = btone_half(1'b0, cfg_r.freq[`BTONE_FREQ0_LSB +: 2]);
  wire logic [19:0] lim1 = btone_half(1'b1, cfg_r.freq[`BTONE_FREQ1_LSB +: 2]);

  // read data mux
  wire logic rd_func = (i_s_araddr == `BTONE_ADDR_FUNC);
  wire logic rd_freq = (i_s_araddr == `BTONE_ADDR_FREQ);
  wire logic rd_dir = (i_s_araddr == `BTONE_ADDR_DIR);
  wire logic rd_latch = (i_s_araddr == `BTONE_ADDR_LATCH);
  wire logic rd_pins = (i_s_araddr == `BTONE_ADDR_PINS);
  wire logic rd_hit = rd_func | rd_freq | rd_dir | rd_latch | rd_pins;
  wire logic [3:0] rd_val =
    rd_func ? {2'h0, cfg_r.func[1:0]} :
    rd_freq ? cfg_r.freq :
    rd_dir ? cfg_r.dir :
    rd_latch ? cfg_r.latch :
    rd_pins ? pin_in_r : 4'h0;

  // pin mux: tone where routed, latch otherwise; enable from direction
  always_comb
  begin
    pins_nxt.oe = cfg_r.dir;
    pins_nxt.out = cfg_r.latch;
    if (cfg_r.func[0])
    begin
      pins_nxt.out[0] = tone0_r;
    end
    if (cfg_r.func[1])
    begin
      pins_nxt.out[1] = tone1_r;
    end
  end

  // configuration registers
  always_ff @(posedge i_mclk)
  begin
    // power-on and watchdog resets clear every register
    if (hard_clr)
    begin
      cfg_r.freq <= `BTONE_RST_FREQ;
      cfg_r.func <= `BTONE_RST_FUNC;
      cfg_r.dir <= `BTONE_RST_DIR;
      cfg_r.latch <= `BTONE_RST_LATCH;
    end
    // ce reset and clock stop return the pins to port use but keep direction and latch
    else if (soft_clr)
    begin
      cfg_r.freq <= `BTONE_RST_FREQ;
      cfg_r.func <= `BTONE_RST_FUNC;
    end
    // writes land only when byte lane 0 is enabled
    else if (wlane)
    begin
      // halt stops only the cpu; registers simply keep value
      if (wr_freq)
      begin
        cfg_r.freq <= wval;
      end
      if (wr_func)
      begin
        cfg_r.func <= {2'h0, wval[1:0]};
      end
      if (wr_dir)
      begin
        cfg_r.dir <= wval;
      end
      if (wr_latch)
      begin
        cfg_r.latch <= wval;
      end
    end
  end

  // channel 0 generator: toggle each half period
  always_ff @(posedge i_mclk)
  begin
    if (hard_clr | soft_clr | ~cfg_r.func[0])
    begin
      // routing off or reset: counter parked and output low
      cnt0_r <= 20'h00000;
      tone0_r <= 1'b0;
    end
    else if (cnt0_r >= lim0 - 20'h00001)
    begin
      // half period done; the compare also catches a shorter period chosen mid-count
      cnt0_r <= 20'h00000;
      tone0_r <= ~tone0_r;
    end
    else
    begin
      // still inside the half period
      cnt0_r <= cnt0_r + 20'h00001;
    end
  end

  // channel 1 generator: toggle each half period
  always_ff @(posedge i_mclk)
  begin
    if (hard_clr | soft_clr | ~cfg_r.func[1])
    begin
      // routing off or reset: counter parked and output low
      cnt1_r <= 20'h00000;
      tone1_r <= 1'b0;
    end
    else if (cnt1_r >= lim1 - 20'h00001)
    begin
      // half period done; the compare also catches a shorter period chosen mid-count
      cnt1_r <= 20'h00000;
      tone1_r <= ~tone1_r;
    end
    else
    begin
      // still inside the half period
      cnt1_r <= cnt1_r + 20'h00001;
    end
  end

  // registered pin outputs; halt leaves them running unchanged
  always_ff @(posedge i_mclk)
  begin
    // hard resets turn every pin into an input
    if (hard_clr)
    begin
      o_pin_out <= 4'h0;
      o_pin_oe <= 4'h0;
    end
    else
    begin
      // soft resets reach the pins through the cleared routing bits
      o_pin_out <= pins_nxt.out;
      o_pin_oe <= pins_nxt.oe;
    end
  end

  // input sampling for reads
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      pin_in_r <= 4'h0;
    end
    else
    begin
      pin_in_r <= i_pin_in;
    end
  end

  // write address and data capture, either order
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      o_s_awready <= 1'b0;
      o_s_wready <= 1'b0;
    end
    else
    begin
      // readies drop while a beat is held and stay low until the pending response is taken,
      // so only one write is ever under way
      o_s_awready <= ~aw_have_r & ~(i_s_awvalid & o_s_awready) & ~(o_s_bvalid & ~i_s_bready);
      o_s_wready <= ~w_have_r & ~(i_s_wvalid & o_s_wready) & ~(o_s_bvalid & ~i_s_bready);
      // address beat
      if (i_s_awvalid & o_s_awready)
      begin
        aw_have_r <= 1'b1;
        awaddr_r <= i_s_awaddr;
      end
      else if (do_write)
      begin
        aw_have_r <= 1'b0;
      end
      // data beat
      if (i_s_wvalid & o_s_wready)
      begin
        w_have_r <= 1'b1;
        wdata_r <= i_s_wdata;
        wstrb_r <= i_s_wstrb;
      end
      else if (do_write)
      begin
        w_have_r <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_s_bvalid <= 1'b0;
      o_s_bresp <= `BTONE_RESP_OKAY;
    end
    // both beats held: answer, slave error for an unmapped address
    else if (do_write)
    begin
      o_s_bvalid <= 1'b1;
      o_s_bresp <= wr_hit ? `BTONE_RESP_OKAY : `BTONE_RESP_SLVERR;
    end
    // released at the edge where the master takes it
    else if (i_s_bready)
    begin
      o_s_bvalid <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_s_arready <= 1'b0;
      o_s_rvalid <= 1'b0;
      o_s_rdata <= 32'h00000000;
      o_s_rresp <= `BTONE_RESP_OKAY;
    end
    else
    begin
      o_s_arready <= ~o_s_rvalid & ~do_read;
      // answer one cycle after the address is taken
      if (do_read)
      begin
        o_s_rvalid <= 1'b1;
        o_s_rdata <= {28'h0000000, rd_val};
        o_s_rresp <= rd_hit ? `BTONE_RESP_OKAY : `BTONE_RESP_SLVERR;
      end
      // held with its data until the master takes it
      else if (i_s_rready)
      begin
        o_s_rvalid <= 1'b0;
      end
    end
  end

endmodule : btone_top
`default_nettype wire

// File: testbench/btone_assertions.sv
// checker for the tone block bus handshakes and pin enables
`timescale 1ns/1ps
`default_nettype none

module btone_chk
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_wdt_rst,
  input wire logic i_s_arvalid,
  input wire logic o_s_arready,
  input wire logic o_s_rvalid,
  input wire logic i_s_rready,
  input wire logic [31:0] o_s_rdata,
  input wire logic o_s_bvalid,
  input wire logic i_s_bready,
  input wire logic [1:0] o_s_bresp,
  input wire logic o_s_awready,
  input wire logic [3:0] o_pin_oe
);
  // one clock domain, one reset
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  a_reset_idle: assert property ($rose(i_rst_n) |-> o_pin_oe == 4'h0 && !o_s_bvalid)
    else $error("outputs not idle after reset");
  a_wdt_input: assert property (i_wdt_rst |-> ##[1:2] o_pin_oe == 4'h0)
    else $error("pins not inputs after watchdog reset");
  a_rd_answer: assert property (i_s_arvalid && o_s_arready |=> o_s_rvalid)
    else $error("read answer late");
  a_rd_hold: assert property (o_s_rvalid && !i_s_rready |=> o_s_rvalid && $stable(o_s_rdata))
    else $error("read data dropped before taken");
  a_rd_upper: assert property (o_s_rvalid |-> o_s_rdata[31:4] == 28'h0000000)
    else $error("upper read bits not zero");
  a_ar_block: assert property (o_s_rvalid |-> !o_s_arready)
    else $error("read address taken while answer pending");
  a_wr_hold: assert property (o_s_bvalid && !i_s_bready |=> o_s_bvalid && $stable(o_s_bresp))
    else $error("write response dropped before taken");
  a_aw_block: assert property (o_s_bvalid |-> !o_s_awready)
    else $error("write address taken while response pending");

  // main scenarios reached
  c_read: cover property (o_s_rvalid && i_s_rready);
  c_write: cover property (o_s_bvalid && i_s_bready);
  c_drive: cover property ($rose(o_pin_oe[0]));
endmodule : btone_chk

bind btone_top btone_chk u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wdt_rst(i_wdt_rst),
  .i_s_arvalid(i_s_arvalid), .o_s_arready(o_s_arready), .o_s_rvalid(o_s_rvalid), .i_s_rready(i_s_rready),
  .o_s_rdata(o_s_rdata), .o_s_bvalid(o_s_bvalid), .i_s_bready(i_s_bready), .o_s_bresp(o_s_bresp),
  .o_s_awready(o_s_awready), .o_pin_oe(o_pin_oe));

`default_nettype wire

// File: testbench/btone_buzzer.sv
// sound transducer model: times high and low spans of both tone pins
`timescale 1ns/1ps
`default_nettype none

module btone_buzzer
(
  input wire logic i_mclk,
  input wire logic [1:0] i_pin,
  input wire logic [1:0] i_oe,
  output int o_hi [2],
  output int o_lo [2]
);
  int cnt [2]; // cycles since last level change
  logic [1:0] last_r = 2'b00; // level seen one edge ago

  // only a driven pin is timed, an undriven one moves no cone
  always @(posedge i_mclk)
  begin
    for (int k = 0; k < 2; k++)
    begin
      cnt[k] <= cnt[k] + 1;
      if (i_oe[k] && i_pin[k] != last_r[k])
      begin
        if (last_r[k])
          o_hi[k] <= cnt[k];
        else
          o_lo[k] <= cnt[k];
        cnt[k] <= 1;
      end
      last_r[k] <= i_pin[k];
    end
  end
endmodule : btone_buzzer

`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the tone output block
`timescale 1ns/1ps
`default_nettype none
`include "btone_defines.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; $display("Error %s exp %h got %h", nm, e, g); end end

module tb;
  logic mclk = 1'b0, rst_n = 1'b0, wdt = 1'b0, ce = 1'b0, stp = 1'b0, halt = 1'b0; // clock, resets, halt
  logic [11:0] awaddr = 12'h000, araddr = 12'h000; // bus addresses
  logic [31:0] wdata = 32'h00000000; // write data
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0; // handshakes
  logic awready, wready, bvalid, arready, rvalid; // slave handshakes
  logic [1:0] bresp, rresp; // responses
  logic [1:0] wresp = 2'h0; // response taken by the last write
  logic [31:0] rdata; // read data
  logic [3:0] pout, poe; // pin drive and enable
  int hi [2], lo [2]; // measured tone spans
  int err_total = 0, total_checks = 0; // verdict counters

  btone_top uut (.i_mclk(mclk), .i_rst_n(rst_n), .i_wdt_rst(wdt), .i_ce_rst(ce), .i_clk_stop(stp),
    .i_halt(halt), .i_pin_in(pout), .i_s_awaddr(awaddr), .i_s_awprot(3'h0), .i_s_awvalid(awvalid),
    .o_s_awready(awready), .i_s_wdata(wdata), .i_s_wstrb(4'hF), .i_s_wvalid(wvalid), .o_s_wready(wready),
    .o_s_bresp(bresp), .o_s_bvalid(bvalid), .i_s_bready(bready), .i_s_araddr(araddr), .i_s_arprot(3'h0),
    .i_s_arvalid(arvalid), .o_s_arready(arready), .o_s_rdata(rdata), .o_s_rresp(rresp), .o_s_rvalid(rvalid),
    .i_s_rready(rready), .o_pin_out(pout), .o_pin_oe(poe));

  btone_buzzer bz (.i_mclk(mclk), .i_pin(pout[1:0]), .i_oe(poe[1:0]), .o_hi(hi), .o_lo(lo));

  // 100 mhz clock
  initial
  begin
    forever #5 mclk = ~mclk;
  end

  // register write: address and data offered together, response taken late
  task automatic wr(input logic [11:0] a, input logic [3:0] d);
    logic pa;
    logic pw;
    awaddr <= a;
    wdata <= {28'h0000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw)
    begin
      @(posedge mclk);
      if (awready && pa)
      begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (wready && pw)
      begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid)
      @(posedge mclk);
    bready <= 1'b1;
    @(posedge mclk);
    wresp = bresp;
    bready <= 1'b0;
    @(posedge mclk);
  endtask : wr

  // register read: answer held one cycle before rready rises
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    @(posedge mclk);
    while (!arready)
      @(posedge mclk);
    arvalid <= 1'b0;
    while (!rvalid)
      @(posedge mclk);
    rready <= 1'b1;
    @(posedge mclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge mclk);
  endtask : rd

  // verdict and end of run
  task automatic conclude();
    if (err_total == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  // main sequence
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic [11:0] ad [3];
    ad = '{`BTONE_ADDR_FUNC, `BTONE_ADDR_FREQ, `BTONE_ADDR_DIR};
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    foreach (ad[k])
    begin
      rd(ad[k], d, r);
      `CHK("reset value", 32'h00000000, d)
    end
    rd(12'h100, d, r);
    `CHK("unmapped resp", `BTONE_RESP_SLVERR, r)
    wr(12'h100, 4'h1);
    `CHK("unmapped write resp", `BTONE_RESP_SLVERR, wresp)
    wr(`BTONE_ADDR_DIR, 4'hF);
    `CHK("dir write resp", `BTONE_RESP_OKAY, wresp)
    wr(`BTONE_ADDR_LATCH, 4'hC);
    repeat (3) @(posedge mclk);
    `CHK("latch drive", 4'hC, pout)
    `CHK("pin enable", 4'hF, poe)
    // pins loop back into the status register
    rd(`BTONE_ADDR_PINS, d, r);
    `CHK("pin status", 32'h0000000C, d)
    wr(`BTONE_ADDR_FUNC, 4'hF);
    rd(`BTONE_ADDR_FUNC, d, r);
    `CHK("func readback", 32'h00000003, d)
    wr(`BTONE_ADDR_FREQ, 4'h3);
    rd(`BTONE_ADDR_FREQ, d, r);
    `CHK("freq readback", 32'h00000003, d)
    halt <= 1'b1;
    // three half periods of the slower tone
    repeat (40000) @(posedge mclk);
    `CHK("tone0 high", 7462, hi[0])
    `CHK("tone0 low", 7462, lo[0])
    `CHK("tone1 high", 12500, hi[1])
    `CHK("tone1 low", 12500, lo[1])
    halt <= 1'b0;
    // other codes: the running half period already ends at the new length
    wr(`BTONE_ADDR_FREQ, 4'h6);
    repeat (34000) @(posedge mclk);
    `CHK("tone0 4k high", `BTONE_HALF(`BTONE_F_4K), hi[0])
    `CHK("tone0 4k low", `BTONE_HALF(`BTONE_F_4K), lo[0])
    `CHK("tone1 3k high", `BTONE_HALF(`BTONE_F_3K), hi[1])
    `CHK("tone1 3k low", `BTONE_HALF(`BTONE_F_3K), lo[1])
    // clock stop then ce reset
    for (int k = 0; k < 2; k++)
    begin
      wr(`BTONE_ADDR_FUNC, 4'h3);
      {ce, stp} <= k ? 2'b10 : 2'b01;
      @(posedge mclk);
      {ce, stp} <= 2'b00;
      repeat (3) @(posedge mclk);
      rd(`BTONE_ADDR_FUNC, d, r);
      `CHK("func after stop", 32'h00000000, d)
      rd(`BTONE_ADDR_DIR, d, r);
      `CHK("dir kept", 32'h0000000F, d)
      `CHK("port drive back", 4'hC, pout)
    end
    wdt <= 1'b1;
    @(posedge mclk);
    wdt <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK("enable after wdt", 4'h0, poe)
    rd(`BTONE_ADDR_DIR, d, r);
    `CHK("dir after wdt", 32'h00000000, d)
    conclude();
  end

  // hang guard
  initial
  begin
    #1000000;
    err_total++;
    conclude();
  end
endmodule : tb

`default_nettype wire
